// ---- ecp_cfg.svh ----
`ifndef ECP_CFG_SVH
`define ECP_CFG_SVH
// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define ECP_CLK_NS 10
`define ECP_FILT_NS 75
`define ECP_FILT_CYC ((`ECP_FILT_NS + `ECP_CLK_NS - 1) / `ECP_CLK_NS)
`define ECP_TURN_NS 80
`define ECP_TURN_CYC ((`ECP_TURN_NS + `ECP_CLK_NS - 1) / `ECP_CLK_NS)
// ---------------------------------------------------------------
// structure
// ---------------------------------------------------------------
`define ECP_FIFO_DEPTH 8
`define ECP_NUM_IN 3
`define ECP_IN_BUSY 0
`define ECP_IN_RSTB 1
`define ECP_IN_RREQ 2
`define ECP_FLT_RST 3'h6
`endif

// ---- ecp_pkg.sv ----
package ecp_pkg;
   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic cmd;
      logic [7:0] data;
   } ecp_word_t;

   typedef enum logic [8:0] {
      ST_FIDLE = 9'h001,
      ST_FDLY = 9'h002,
      ST_FSTB = 9'h004,
      ST_FREL = 9'h008,
      ST_FEND = 9'h010,
      ST_RIDLE = 9'h020,
      ST_RDLY = 9'h040,
      ST_RACK = 9'h080,
      ST_RREL = 9'h100
   } ecp_state_t;
endpackage : ecp_pkg

// ---- ecp_fifo.sv ----
`timescale 1ns/1ns
module ecp_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 8
) (
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic in_valid_in,
   input wire logic [WIDTH-1:0] in_data_in,
   output logic in_ready_out,
   output logic out_valid_out,
   output logic [WIDTH-1:0] out_data_out,
   input wire logic out_ready_in
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0] wp_ff;
   logic [AW-1:0] rp_ff;
   logic [AW:0] cnt_ff;
   logic [AW:0] nxt_cnt;
   logic [AW:0] nxt_fill;
   logic in_ready_ff;
   logic out_valid_ff;
   logic [WIDTH-1:0] out_data_ff;

   // push and prefetch into the output register
   wire push = in_valid_in && in_ready_ff;
   wire load = (cnt_ff != '0) && (!out_valid_ff || out_ready_in);
   wire nxt_out_valid = load || (out_valid_ff && !out_ready_in);
   assign nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(load);
   assign nxt_fill = nxt_cnt + (AW+1)'(nxt_out_valid); // output stage counts toward depth
   assign in_ready_out = in_ready_ff;
   assign out_valid_out = out_valid_ff;
   assign out_data_out = out_data_ff;

   // storage array, no reset needed
   always_ff @(posedge sys_clk_in) begin
      if (push) mem_ff[wp_ff] <= in_data_in;
   end

   // pointers, fill level and output stage
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         wp_ff <= '0;
         rp_ff <= '0;
         cnt_ff <= '0;
         in_ready_ff <= 1'b1;
         out_valid_ff <= 1'b0;
         out_data_ff <= '0;
      end else begin
         if (push) wp_ff <= (wp_ff == AW'(DEPTH - 1)) ? '0 : wp_ff + 1'b1;
         if (load) rp_ff <= (rp_ff == AW'(DEPTH - 1)) ? '0 : rp_ff + 1'b1;
         cnt_ff <= nxt_cnt;
         in_ready_ff <= (nxt_fill != (AW+1)'(DEPTH));
         if (load) out_data_ff <= mem_ff[rp_ff];
         out_valid_ff <= nxt_out_valid;
      end
   end
endmodule : ecp_fifo

// ---- ecp_handshake.sv ----
`timescale 1ns/1ns
`include "ecp_cfg.svh"
module ecp_handshake (
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic ecp_mode_in,
   input wire logic fifo_mode_in,
   input wire logic dir_reverse_in,
   input wire logic term_count_in,
   input wire logic tx_valid_in,
   input wire ecp_pkg::ecp_word_t tx_word_in,
   output logic tx_ready_out,
   output logic rx_valid_out,
   output ecp_pkg::ecp_word_t rx_word_out,
   input wire logic rx_ready_in,
   output logic reverse_request_out,
   output logic dir_reverse_out,
   input wire logic busy_pin_in,
   input wire logic periph_pulse_pin_in,
   input wire logic periph_fault_pin_in,
   input wire logic [7:0] port_data_lines_in,
   output logic [7:0] port_data_lines_out,
   output logic port_data_lines_oe_out,
   output logic host_pulse_pin_out,
   output logic host_pulse_pin_oe_out,
   output logic host_feed_pin_out,
   output logic host_feed_pin_oe_out
);
   import ecp_pkg::*;

   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   logic [`ECP_NUM_IN-1:0] raw_in;
   logic [`ECP_NUM_IN-1:0] s1_ff;
   logic [`ECP_NUM_IN-1:0] s2_ff;
   logic [`ECP_NUM_IN-1:0] flt_ff;
   logic [7:0] d1_ff;
   logic [7:0] d2_ff;
   ecp_state_t state_ff;
   ecp_state_t nxt_state;
   logic [3:0] dly_ff;
   logic [3:0] nxt_dly;
   logic strobe_ff;
   logic feed_ff;
   logic nxt_feed;
   logic pp_ff;
   logic nxt_pp;
   logic tc_ff;
   logic [7:0] data_ff;
   logic data_oe_ff;
   logic strobe_oe_ff;
   logic feed_oe_ff;
   logic rreq_ff;
   logic dir_ff;
   logic tx_valid;
   ecp_word_t tx_word;
   logic rx_room;
   ecp_word_t rx_word;

   // ---------------------------------------------------------------
   // input synchronisers and deglitch filters
   // ---------------------------------------------------------------
   assign raw_in = {periph_fault_pin_in, periph_pulse_pin_in, busy_pin_in};
   localparam logic [`ECP_NUM_IN-1:0] FLT_RST = `ECP_FLT_RST;

   // data lines: two flops, settled by the strobe filter before use
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         d1_ff <= 8'h00;
         d2_ff <= 8'h00;
      end else begin
         d1_ff <= port_data_lines_in;
         d2_ff <= d1_ff;
      end
   end

   generate
      for (genvar i = 0; i < `ECP_NUM_IN; i++) begin : g_flt
         logic [3:0] cnt_ff;
         wire differs = (s2_ff[i] != flt_ff[i]);
         wire held = differs && (cnt_ff == 4'(`ECP_FILT_CYC - 1));
         // two-flop sync, then a held-level counter
         always_ff @(posedge sys_clk_in or posedge rst_in) begin
            if (rst_in) begin
               s1_ff[i] <= FLT_RST[i];
               s2_ff[i] <= FLT_RST[i];
               flt_ff[i] <= FLT_RST[i];
               cnt_ff <= 4'h0;
            end else begin
               s1_ff[i] <= raw_in[i];
               s2_ff[i] <= s1_ff[i];
               cnt_ff <= (differs && !held) ? cnt_ff + 4'h1 : 4'h0;
               if (held) flt_ff[i] <= s2_ff[i];
            end
         end
         a_flt_hold_level: assert property (@(posedge sys_clk_in) disable iff (rst_in)
            $changed(flt_ff[i]) |-> $past(s2_ff[i], 1) == flt_ff[i]
               && $past(s2_ff[i], 8) == flt_ff[i])
            else $error("filtered input changed before hold time");
      end
   endgenerate

   wire busy_flt = flt_ff[`ECP_IN_BUSY];
   wire rstb_flt = flt_ff[`ECP_IN_RSTB];
   wire rreq_flt = flt_ff[`ECP_IN_RREQ];

   // ---------------------------------------------------------------
   // fifos in the forward and reverse data path
   // ---------------------------------------------------------------
   wire st_fidle = (state_ff == ST_FIDLE);
   wire st_fdly = (state_ff == ST_FDLY);
   wire st_fstb = (state_ff == ST_FSTB);
   wire st_frel = (state_ff == ST_FREL);
   wire st_fend = (state_ff == ST_FEND);
   wire st_ridle = (state_ff == ST_RIDLE);
   wire st_rdly = (state_ff == ST_RDLY);
   wire st_rack = (state_ff == ST_RACK);
   wire st_rrel = (state_ff == ST_RREL);
   wire in_dly = st_fdly || st_frel || st_rdly || st_rrel;
   wire dly_done = (dly_ff == 4'(`ECP_TURN_CYC - 1));

   // reverse entry only in push-pull ecp mode, never in fifo mode
   wire go_rev = st_fidle && dir_reverse_in && pp_ff && !fifo_mode_in;
   // forward start needs a waiting byte and ack low
   wire go_fwd = st_fidle && !go_rev && tx_valid && !busy_flt;
   wire rev_take = st_ridle && dir_reverse_in && !rstb_flt && rx_room && !tc_ff;
   wire rx_push = st_rdly && dly_done;
   assign rx_word = '{cmd: !busy_flt, data: d2_ff};

   ecp_fifo #(.WIDTH($bits(ecp_word_t)), .DEPTH(`ECP_FIFO_DEPTH)) u_tx_fifo (
      .sys_clk_in(sys_clk_in),
      .rst_in(rst_in),
      .in_valid_in(tx_valid_in),
      .in_data_in(tx_word_in),
      .in_ready_out(tx_ready_out),
      .out_valid_out(tx_valid),
      .out_data_out(tx_word),
      .out_ready_in(go_fwd)
   );

   ecp_fifo #(.WIDTH($bits(ecp_word_t)), .DEPTH(`ECP_FIFO_DEPTH)) u_rx_fifo (
      .sys_clk_in(sys_clk_in),
      .rst_in(rst_in),
      .in_valid_in(rx_push),
      .in_data_in(rx_word),
      .in_ready_out(rx_room),
      .out_valid_out(rx_valid_out),
      .out_data_out(rx_word_out),
      .out_ready_in(rx_ready_in)
   );

   // ---------------------------------------------------------------
   // transfer state machine
   // ---------------------------------------------------------------
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         ST_FIDLE: begin
            if (go_rev) nxt_state = ST_RIDLE;
            else if (go_fwd) nxt_state = ST_FDLY;
         end
         ST_FDLY: if (dly_done) nxt_state = ST_FSTB;
         ST_FSTB: if (busy_flt) nxt_state = ST_FREL;
         ST_FREL: if (dly_done) nxt_state = ST_FEND;
         ST_FEND: if (!busy_flt) nxt_state = ST_FIDLE;
         ST_RIDLE: begin
            if (!dir_reverse_in) nxt_state = ST_FIDLE;
            else if (rev_take) nxt_state = ST_RDLY;
         end
         ST_RDLY: if (dly_done) nxt_state = ST_RACK;
         ST_RACK: if (rstb_flt) nxt_state = ST_RREL;
         ST_RREL: if (dly_done) nxt_state = ST_RIDLE;
         default: nxt_state = ST_FIDLE;
      endcase
   end

   // turnaround counter runs only inside the delay states
   assign nxt_dly = (in_dly && !dly_done) ? dly_ff + 4'h1 : 4'h0;

   // reverse ack: low at entry, high after capture delay, low after release
   always_comb begin
      nxt_feed = feed_ff;
      if (go_rev) nxt_feed = 1'b0;
      else if (go_fwd) nxt_feed = !(tx_word.cmd && !fifo_mode_in);
      else if (st_ridle && !dir_reverse_in) nxt_feed = 1'b1;
      else if (st_rdly && dly_done) nxt_feed = 1'b1;
      else if (st_rrel && dly_done) nxt_feed = 1'b0;
   end

   // driver style changes only while the port is idle and strobe is high
   assign nxt_pp = (st_fidle && strobe_ff) ? ecp_mode_in : pp_ff;

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_ff <= ST_FIDLE;
         dly_ff <= 4'h0;
         strobe_ff <= 1'b1;
         feed_ff <= 1'b1;
         pp_ff <= 1'b0;
         tc_ff <= 1'b0;
         data_ff <= 8'h00;
      end else begin
         state_ff <= nxt_state;
         dly_ff <= nxt_dly;
         if (st_fdly && dly_done) strobe_ff <= 1'b0;
         else if (st_frel && dly_done) strobe_ff <= 1'b1;
         feed_ff <= nxt_feed;
         pp_ff <= nxt_pp;
         tc_ff <= term_count_in || (tc_ff && !st_fidle);
         if (go_fwd) data_ff <= tx_word.data;
      end
   end

   // pad enables follow the next level so a level and its enable move together
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         data_oe_ff <= 1'b1;
         strobe_oe_ff <= 1'b0;
         feed_oe_ff <= 1'b0;
         rreq_ff <= 1'b0;
         dir_ff <= 1'b0;
      end else begin
         data_oe_ff <= !nxt_state[5] && !nxt_state[6] && !nxt_state[7] && !nxt_state[8];
         strobe_oe_ff <= nxt_pp || !((st_fdly && dly_done) ? 1'b0 :
            (st_frel && dly_done) ? 1'b1 : strobe_ff);
         feed_oe_ff <= nxt_pp || !nxt_feed;
         rreq_ff <= !rreq_flt && !dir_ff;
         dir_ff <= nxt_state[5] || nxt_state[6] || nxt_state[7] || nxt_state[8];
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign port_data_lines_out = data_ff;
   assign port_data_lines_oe_out = data_oe_ff;
   assign host_pulse_pin_out = strobe_ff;
   assign host_pulse_pin_oe_out = strobe_oe_ff;
   assign host_feed_pin_out = feed_ff;
   assign host_feed_pin_oe_out = feed_oe_ff;
   assign reverse_request_out = rreq_ff;
   assign dir_reverse_out = dir_ff;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   sequence s_fwd_start;
      go_fwd ##1 st_fdly [*8];
   endsequence

   sequence s_rev_take;
      rev_take ##1 st_rdly [*8];
   endsequence

   a_fifo_mode_fwd: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      fifo_mode_in && st_fidle |=> !st_ridle)
      else $error("reverse entered in fifo mode");

   a_fwd_idle_strobe: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      st_fidle |-> strobe_ff)
      else $error("strobe low in forward idle");

   a_strobe_fall_time: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      s_fwd_start |=> !strobe_ff && st_fstb)
      else $error("strobe did not fall after turnaround");

   a_strobe_release: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      st_fstb && busy_flt |-> ##9 strobe_ff && st_fend)
      else $error("strobe not released after ack");

   a_data_setup: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      $fell(strobe_ff) |-> data_oe_ff && $past(data_ff, 8) == data_ff)
      else $error("data not stable before strobe");

   a_no_byte_idle: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      st_fidle && !tx_valid |=> strobe_ff && !st_fdly)
      else $error("strobe started without queued byte");

   a_rev_idle_ack: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      st_ridle |-> !feed_ff && !port_data_lines_oe_out)
      else $error("reverse ack high in reverse idle");

   a_rev_ack_rise: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      s_rev_take |=> feed_ff && st_rack)
      else $error("reverse ack did not rise after capture");

   a_rev_ack_drop: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      st_rack && rstb_flt |-> ##9 !feed_ff && st_ridle)
      else $error("reverse ack not dropped after release");

   a_rev_stall_ack: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      st_ridle && dir_reverse_in && !rstb_flt && (!rx_room || tc_ff) |=> st_ridle && !feed_ff)
      else $error("reverse ack given while stalled");

   a_drive_switch: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      $changed(pp_ff) |-> $past(st_fidle && strobe_ff) && strobe_ff)
      else $error("driver style changed outside idle");
endmodule : ecp_handshake

// ---- ecp_periph_model.sv ----
`timescale 1ns/1ns
module ecp_periph_model (
   input wire logic sys_clk_in,
   input wire logic strobe_wire_in,
   input wire logic feed_wire_in,
   input wire logic [7:0] data_wire_in,
   input wire logic reverse_in,
   input wire logic periph_pulse_pin_low_in,
   input wire logic [3:0] lag_in,
   output logic busy_out,
   output logic pulse_out,
   output logic [7:0] data_out
);
   // ---------------------------------------------------------------
   // queues shared with the bench
   // ---------------------------------------------------------------
   logic [8:0] got_q[$];
   logic [7:0] send_q[$];
   logic rstb_ff;

   // ack pulse pin may be held low to show it is not used forward
   assign pulse_out = rstb_ff & ~periph_pulse_pin_low_in;

   // forward: ack after strobe falls, drop after strobe rises
   initial begin
      busy_out = 1'b0;
      forever begin
         @(negedge strobe_wire_in);
         got_q.push_back({feed_wire_in, data_wire_in});
         repeat (lag_in + 1) @(posedge sys_clk_in);
         busy_out <= 1'b1;
         @(posedge strobe_wire_in);
         @(posedge sys_clk_in);
         busy_out <= 1'b0;
      end
   end

   // reverse: strobe low with data, release after host ack
   initial begin
      rstb_ff = 1'b1;
      data_out = 8'hFF;
      forever begin
         @(posedge sys_clk_in);
         if (reverse_in && send_q.size() > 0 && feed_wire_in === 1'b0) begin
            data_out <= send_q[0];
            @(posedge sys_clk_in);
            rstb_ff <= 1'b0;
            wait (feed_wire_in === 1'b1);
            repeat (lag_in + 1) @(posedge sys_clk_in);
            rstb_ff <= 1'b1;
            data_out <= ~send_q.pop_front();
            wait (feed_wire_in === 1'b0);
         end
      end
   end
endmodule : ecp_periph_model

// ---- ecp_parallel_handshake_tb_top.sv ----
`timescale 1ns/1ns
module ecp_parallel_handshake_tb_top;
   import ecp_pkg::*;
   // ---------------------------------------------------------------
   // signals
   // ---------------------------------------------------------------
   logic clk = 1'b0, rst = 1'b1, ecp_mode = 1'b0, fifo_mode = 1'b0, dir_rev = 1'b0;
   logic tx_valid = 1'b0, rx_ready = 1'b0, fault = 1'b1, periph_pulse_pin_low = 1'b0;
   logic [3:0] lag = 4'h0;
   logic tc = 1'b0;
   ecp_word_t tx_word = '0;
   ecp_word_t rx_word;
   logic tx_ready, rx_valid, rev_req, dir_rev_out, busy, pulse;
   logic [7:0] pd_out, per_data;
   logic pd_oe, stb, stb_oe, feed, feed_oe;
   wire strobe_w = stb_oe ? stb : 1'b1;
   wire feed_w = feed_oe ? feed : 1'b1;
   wire [7:0] data_w = pd_oe ? pd_out : per_data;
   int n_mismatch = 0;
   int tests_run = 0;

   // clock and reset
   initial begin
      forever #5 clk = ~clk;
   end
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
   end

   ecp_handshake dut (.sys_clk_in(clk), .rst_in(rst), .ecp_mode_in(ecp_mode),
      .fifo_mode_in(fifo_mode), .dir_reverse_in(dir_rev), .term_count_in(tc),
      .tx_valid_in(tx_valid), .tx_word_in(tx_word), .tx_ready_out(tx_ready),
      .rx_valid_out(rx_valid), .rx_word_out(rx_word), .rx_ready_in(rx_ready),
      .reverse_request_out(rev_req), .dir_reverse_out(dir_rev_out),
      .busy_pin_in(busy), .periph_pulse_pin_in(pulse), .periph_fault_pin_in(fault),
      .port_data_lines_in(data_w), .port_data_lines_out(pd_out),
      .port_data_lines_oe_out(pd_oe), .host_pulse_pin_out(stb),
      .host_pulse_pin_oe_out(stb_oe), .host_feed_pin_out(feed),
      .host_feed_pin_oe_out(feed_oe));

   ecp_periph_model periph (.sys_clk_in(clk), .strobe_wire_in(strobe_w),
      .feed_wire_in(feed_w), .data_wire_in(data_w), .reverse_in(dir_rev_out),
      .periph_pulse_pin_low_in(periph_pulse_pin_low), .lag_in(lag), .busy_out(busy), .pulse_out(pulse),
      .data_out(per_data));

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] expected);
      tests_run++;
      if (seen !== expected) begin
         n_mismatch++;
         $display("unexpected at %0t: saw %h expected %h", $time, seen, expected);
      end
   endtask : check

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : summarize

   // push words into the transmit fifo, one per accepted edge
   task automatic push(input ecp_word_t w[]);
      foreach (w[i]) begin
         tx_valid <= 1'b1;
         tx_word <= w[i];
         do @(posedge clk); while (tx_ready !== 1'b1);
      end
      tx_valid <= 1'b0;
   endtask : push

   task automatic wait_got(input int n);
      for (int i = 0; i < 2000 && periph.got_q.size() < n; i++) @(posedge clk);
      repeat (30) @(posedge clk);
   endtask : wait_got

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_reset();
      @(posedge clk);
      check({12'h000, strobe_w, feed_w, tx_ready, rx_valid}, 16'h000E);
      check({14'h0000, rev_req, dir_rev_out}, 16'h0000);
   endtask : t_reset

   task automatic t_forward();
      ecp_word_t w[] = '{'{1'b0, 8'hA5}, '{1'b1, 8'h3C}, '{1'b0, 8'h00}};
      int gap = 0;
      push(w);
      for (int i = 0; i < 200 && busy !== 1'b1; i++) @(posedge clk);
      while (strobe_w !== 1'b1 && gap < 100) begin
         @(posedge clk);
         gap++;
      end
      check({15'h0, gap >= 16 && gap <= 31}, 16'h0001);
      wait_got(3);
      foreach (w[i]) check({7'h00, periph.got_q[i]}, {7'h00, ~w[i].cmd, w[i].data});
      repeat (50) @(posedge clk);
      check({13'h0000, strobe_w, stb_oe, busy}, 16'h0004);
   endtask : t_forward

   task automatic t_fifo_mode();
      ecp_word_t w[] = '{'{1'b1, 8'h81}, '{1'b0, 8'h7E}};
      periph.got_q.delete();
      fifo_mode <= 1'b1;
      periph_pulse_pin_low <= 1'b1;
      push(w);
      wait_got(2);
      check(16'(periph.got_q.size()), 16'h0002);
      foreach (w[i]) check({7'h00, periph.got_q[i]}, {7'h00, 1'b1, w[i].data});
      fifo_mode <= 1'b0;
      periph_pulse_pin_low <= 1'b0;
   endtask : t_fifo_mode

   task automatic t_request();
      fault <= 1'b0;
      repeat (5) @(posedge clk);
      fault <= 1'b1;
      repeat (20) @(posedge clk);
      check({15'h0000, rev_req}, 16'h0000);
      fault <= 1'b0;
      repeat (15) @(posedge clk);
      check({15'h0000, rev_req}, 16'h0001);
      fault <= 1'b1;
      repeat (15) @(posedge clk);
      check({15'h0000, rev_req}, 16'h0000);
   endtask : t_request

   task automatic t_reverse();
      int n = 0;
      int bad = 0;
      ecp_mode <= 1'b1;
      lag <= 4'h3;
      repeat (5) @(posedge clk);
      check({13'h0000, stb_oe, feed_oe, pd_oe}, 16'h0007);
      dir_rev <= 1'b1;
      for (int i = 0; i < 50 && dir_rev_out !== 1'b1; i++) @(posedge clk);
      repeat (3) @(posedge clk);
      check({13'h0000, feed_w, pd_oe, pulse}, 16'h0001);
      for (int i = 0; i < 9; i++) periph.send_q.push_back(8'(i * 17 + 3));
      repeat (600) @(posedge clk);
      // receive fifo full: the ninth byte must be held off
      for (int i = 0; i < 40; i++) begin
         @(posedge clk);
         if (feed_w !== 1'b0 || pulse !== 1'b0) bad++;
      end
      check(16'(bad), 16'h0000);
      rx_ready <= 1'b1;
      for (int i = 0; i < 2000 && n < 9; i++) begin
         @(posedge clk);
         if (rx_valid === 1'b1) begin
            check({7'h00, rx_word}, {7'h00, 1'b1, 8'(n * 17 + 3)});
            n++;
         end
      end
      check(16'(n), 16'h0009);
      // terminal count: one more byte must stall until the port turns forward
      tc <= 1'b1;
      periph.send_q.push_back(8'h5A);
      @(posedge clk);
      tc <= 1'b0;
      repeat (40) @(posedge clk);
      bad = 0;
      for (int i = 0; i < 40; i++) begin
         @(posedge clk);
         if (feed_w !== 1'b0 || rx_valid !== 1'b0) bad++;
      end
      check(16'(bad), 16'h0000);
      dir_rev <= 1'b0;
      for (int i = 0; i < 50 && dir_rev_out !== 1'b0; i++) @(posedge clk);
      repeat (3) @(posedge clk);
      check({13'h0000, feed_w, strobe_w, pd_oe}, 16'h0007);
   endtask : t_reverse

   // ---------------------------------------------------------------
   // main sequence and watchdog
   // ---------------------------------------------------------------
   initial begin
      wait (rst === 1'b0);
      t_reset();
      t_forward();
      t_fifo_mode();
      t_request();
      t_reverse();
      summarize();
   end

   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      summarize();
   end
endmodule : ecp_parallel_handshake_tb_top
